// ===== hw/i2c_rd_pkg.sv
/*
 * Shared constants and types for the I2C master read sequencer.
 * Assumes a single 20 MHz core clock; all bus timing derives from it.
 */
package i2c_rd_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int STD_BIT_NS = 10000;    // 100 kHz standard bit period
    localparam int SLOW_BIT_NS = 20000;   // slowed bit period for slow slaves
    // a bit is split into four quarters; a longest time rounds down
    localparam int STD_QUARTER_CYC = STD_BIT_NS / (4 * CLK_PERIOD_NS);
    localparam int SLOW_QUARTER_CYC = SLOW_BIT_NS / (4 * CLK_PERIOD_NS);
    localparam logic [7:0] STD_QUARTER_LIM = 8'(STD_QUARTER_CYC - 1);
    localparam logic [7:0] SLOW_QUARTER_LIM = 8'(SLOW_QUARTER_CYC - 1);

    // ----------------------------------------------------------------
    // control byte and frame layout
    // ----------------------------------------------------------------
    localparam int RW_BIT = 0;
    localparam logic RW_READ = 1'b1;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [7:0] LIST_MAX = 8'h10;

    // address phase width
    localparam logic [1:0] ADDR_NONE = 2'h0;
    localparam logic [1:0] ADDR_8 = 2'h1;
    localparam logic [1:0] ADDR_16 = 2'h2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_ADDR_VALUE,
        OP_ADDR_LIST,
        OP_ADDR_BYTE,
        OP_LOW_BYTE
    } rd_op_t;

    typedef enum logic [1:0] {
        CMD_START,
        CMD_STOP,
        CMD_WRITE,
        CMD_READ
    } bus_cmd_t;

    typedef enum {E_IDLE, E_START, E_STOP, E_BIT} eng_state_t;

    typedef enum {C_IDLE, C_START, C_CTRL, C_ADDR_HI, C_ADDR_LO, C_READ, C_STOP} seq_state_t;

endpackage : i2c_rd_pkg

// ===== hw/bus_step_if.sv
/*
 * Carrier between the read sequencer and its bit engine.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/100ps
interface bus_step_if;
    import i2c_rd_pkg::*;
    logic cmd_valid;
    bus_cmd_t cmd;
    logic [7:0] tx_byte;
    logic nack_send;
    logic idle;
    logic done;
    logic [7:0] rx_byte;
    logic slave_nack;

    modport seq (output cmd_valid, output cmd, output tx_byte, output nack_send,
                 input idle, input done, input rx_byte, input slave_nack);
    modport eng (input cmd_valid, input cmd, input tx_byte, input nack_send,
                 output idle, output done, output rx_byte, output slave_nack);
endinterface : bus_step_if

// ===== hw/i2c_bit_engine.sv
/*
 * Open-drain I2C bit engine: start, stop, byte write, byte read.
 * Assumes pull-ups on both lines; a command is taken only while idle.
 */
`timescale 1ns/100ps
module i2c_bit_engine
    import i2c_rd_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // rate select
    input wire logic i_slow_bus,
    // bus lines
    input wire logic i_sda,
    input wire logic i_scl,
    output logic o_sda_low,
    output logic o_scl_low,
    // step port
    bus_step_if.eng st
);

    eng_state_t state_r, state_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic sda_r, sda_nxt;
    logic scl_r, scl_nxt;
    logic rd_r, rd_nxt;
    logic ack_lvl_r, ack_lvl_nxt;
    logic nack_r, nack_nxt;
    logic done_r, done_nxt;
    logic tick;
    logic advance;

    // --------------------------------------------------------------
    // quarter-bit divider and next-state logic
    // --------------------------------------------------------------
    always_comb begin
        tick = (cnt_r == (i_slow_bus ? SLOW_QUARTER_LIM : STD_QUARTER_LIM));
        // a slave holding the clock low stretches the high quarter
        advance = tick && !(state_r == E_BIT && phase_r == 2'h2 && !i_scl);
        state_nxt = state_r;
        phase_nxt = phase_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        sda_nxt = sda_r;
        scl_nxt = scl_r;
        rd_nxt = rd_r;
        ack_lvl_nxt = ack_lvl_r;
        nack_nxt = nack_r;
        done_nxt = 1'b0;
        cnt_nxt = (state_r == E_IDLE || tick) ? 8'h00 : cnt_r + 8'h01;
        case (state_r)
            E_IDLE: begin
                phase_nxt = 2'h0;
                bit_nxt = 4'h0;
                if (st.cmd_valid) begin
                    case (st.cmd)
                        CMD_START: state_nxt = E_START;
                        CMD_STOP: state_nxt = E_STOP;
                        CMD_WRITE: begin
                            state_nxt = E_BIT;
                            rd_nxt = 1'b0;
                            sh_nxt = st.tx_byte;
                        end
                        default: begin
                            state_nxt = E_BIT;
                            rd_nxt = 1'b1;
                            ack_lvl_nxt = st.nack_send;
                        end
                    endcase
                end
            end
            E_START: if (advance) begin
                // release both, pull data low under high clock, then clock low
                phase_nxt = phase_r + 2'h1;
                case (phase_r)
                    2'h0: begin
                        sda_nxt = 1'b1;
                        scl_nxt = 1'b1;
                    end
                    2'h1: sda_nxt = 1'b0;
                    2'h2: scl_nxt = 1'b0;
                    default: begin
                        state_nxt = E_IDLE;
                        done_nxt = 1'b1;
                    end
                endcase
            end
            E_STOP: if (advance) begin
                phase_nxt = phase_r + 2'h1;
                case (phase_r)
                    2'h0: begin
                        scl_nxt = 1'b0;
                        sda_nxt = 1'b0;
                    end
                    2'h1: scl_nxt = 1'b1;
                    2'h2: sda_nxt = 1'b1;
                    default: begin
                        state_nxt = E_IDLE;
                        done_nxt = 1'b1;
                    end
                endcase
            end
            E_BIT: if (advance) begin
                phase_nxt = phase_r + 2'h1;
                case (phase_r)
                    2'h0: begin
                        scl_nxt = 1'b0;
                        if (bit_r == ACK_SLOT) begin
                            sda_nxt = rd_r ? ack_lvl_r : 1'b1;
                        end else begin
                            sda_nxt = rd_r ? 1'b1 : sh_r[7];
                        end
                    end
                    2'h1: scl_nxt = 1'b1;
                    2'h2: begin
                        if (bit_r == ACK_SLOT) begin
                            nack_nxt = i_sda;
                        end else begin
                            sh_nxt = {sh_r[6:0], i_sda};
                        end
                    end
                    default: begin
                        scl_nxt = 1'b0;
                        if (bit_r == ACK_SLOT) begin
                            state_nxt = E_IDLE;
                            done_nxt = 1'b1;
                        end else begin
                            bit_nxt = bit_r + 4'h1;
                        end
                    end
                endcase
            end
            default: state_nxt = E_IDLE;
        endcase
    end

    // --------------------------------------------------------------
    // state registers
    // --------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= E_IDLE;
            phase_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            cnt_r <= 8'h00;
            sda_r <= 1'b1;
            scl_r <= 1'b1;
            rd_r <= 1'b0;
            ack_lvl_r <= 1'b1;
            nack_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            sda_r <= sda_nxt;
            scl_r <= scl_nxt;
            rd_r <= rd_nxt;
            ack_lvl_r <= ack_lvl_nxt;
            nack_r <= nack_nxt;
            done_r <= done_nxt;
        end
    end

    // open drain: only ever pull low, pull-ups give the high level
    assign o_sda_low = !sda_r;
    assign o_scl_low = !scl_r;
    assign st.idle = (state_r == E_IDLE);
    assign st.done = done_r;
    assign st.rx_byte = sh_r;
    assign st.slave_nack = nack_r;

endmodule : i2c_bit_engine

// ===== hw/i2c_master_read_sequencer.sv
/*
 * I2C master receive sequencer: control byte, optional address, then
 * one value, a list of values, or a byte array; plus a bare read of one byte or of a byte array.
 * Assumes a host that pulses a start with stable operands, and external
 * pull-ups on both bus lines.
 */
// Notes on behaviour
// - bare one-byte reads end with a not-acknowledge or a stop.
// - control byte bits seven to one carry control code and slave address.
// - control byte bit zero selects read or write.
// - on receive, bit zero is forced to one whatever was supplied.
// - address phase is 8 or 16 bits, chosen by the address width.
// - received bits per value match the destination width.
// - the single-byte addressed form receives only one 8-bit value; with array fill set the code reads the array length of bytes instead.
// - a list receives one value per entry, in order, each sized by its entry; the code reads at most LIST_MAX (16) entries.
// - array fill writes received bytes to consecutive array elements.
// - array fill stops at the given length, else fills the whole array.
// - master switches data and clock pins between driving and released.
// - both lines are open drain, high level from external pull-ups.
// - slaves share the pair, each answering only its own address.
// - bus runs at standard rate, with a slower option for slow slaves.
`timescale 1ns/100ps
module i2c_master_read_sequencer
    import i2c_rd_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // request
    input wire logic i_go,
    input wire rd_op_t i_op,
    input wire logic [7:0] i_ctrl,
    input wire logic [1:0] i_addr_mode,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_item_count,
    input wire logic [15:0] i_item_wide,
    input wire logic i_array_fill,
    input wire logic i_len_given,
    input wire logic [7:0] i_array_len,
    input wire logic [7:0] i_array_size,
    input wire logic i_end_stop,
    input wire logic i_slow_bus,
    // status
    output logic o_busy,
    output logic o_done,
    output logic o_nack_err,
    // received data
    output logic o_data_valid,
    output logic [15:0] o_data,
    output logic [7:0] o_data_index,
    output logic o_data_last,
    // bus pins
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic i_scl,
    output logic o_scl_o,
    output logic o_scl_oe
);

    bus_step_if st ();

    seq_state_t state_r, state_nxt;
    logic wait_r, wait_nxt;
    rd_op_t op_r, op_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [1:0] amode_r, amode_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [7:0] items_r, items_nxt;
    logic [15:0] wide_r, wide_nxt;
    logic array_r, array_nxt;
    logic end_stop_r, end_stop_nxt;
    logic [7:0] item_r, item_nxt;
    logic second_r, second_nxt;
    logic [7:0] hi_r, hi_nxt;
    logic err_r, err_nxt;
    logic done_r, done_nxt;
    logic dv_r, dv_nxt;
    logic [15:0] data_r, data_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic dlast_r, dlast_nxt;
    logic [7:0] count_in;
    logic wide_cur;
    logic last_byte;

    // --------------------------------------------------------------
    // bit engine
    // --------------------------------------------------------------
    logic sda_low;
    logic scl_low;

    i2c_bit_engine u_engine (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_slow_bus(i_slow_bus),
        .i_sda(i_sda),
        .i_scl(i_scl),
        .o_sda_low(sda_low),
        .o_scl_low(scl_low),
        .st(st.eng)
    );

    // pins drive only low; enable high means pulling the line down
    assign o_sda_o = 1'b0;
    assign o_scl_o = 1'b0;
    assign o_sda_oe = sda_low;
    assign o_scl_oe = scl_low;

    // --------------------------------------------------------------
    // per-byte sizing
    // --------------------------------------------------------------
    always_comb begin
        // array fill takes the given length, otherwise the whole array
        if (i_array_fill) begin
            count_in = i_len_given ? i_array_len : i_array_size;
        end else if (i_op == OP_ADDR_LIST) begin
            count_in = (i_item_count > LIST_MAX) ? LIST_MAX : i_item_count;
        end else begin
            count_in = 8'h01;
        end
        // only destinations of a list or a single value can be 16 bits wide
        if (array_r) begin
            wide_cur = 1'b0;
        end else if (op_r == OP_ADDR_LIST) begin
            wide_cur = wide_r[item_r[3:0]];
        end else if (op_r == OP_ADDR_VALUE) begin
            wide_cur = wide_r[0];
        end else begin
            wide_cur = 1'b0;
        end
        last_byte = (item_r == items_r - 8'h01) && (!wide_cur || second_r);
    end

    // --------------------------------------------------------------
    // step commands toward the engine
    // --------------------------------------------------------------
    always_comb begin
        st.cmd_valid = (state_r != C_IDLE) && !wait_r && st.idle;
        st.cmd = CMD_READ;
        st.tx_byte = 8'h00;
        st.nack_send = last_byte;
        case (state_r)
            C_START: st.cmd = CMD_START;
            C_CTRL: begin
                st.cmd = CMD_WRITE;
                // upper seven bits pass untouched, read flag forced
                st.tx_byte = {ctrl_r[7:1], RW_READ};
            end
            C_ADDR_HI: begin
                st.cmd = CMD_WRITE;
                st.tx_byte = addr_r[15:8];
            end
            C_ADDR_LO: begin
                st.cmd = CMD_WRITE;
                st.tx_byte = addr_r[7:0];
            end
            C_STOP: st.cmd = CMD_STOP;
            default: st.cmd = CMD_READ;
        endcase
    end

    // --------------------------------------------------------------
    // sequencer next state
    // --------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        wait_nxt = wait_r;
        op_nxt = op_r;
        ctrl_nxt = ctrl_r;
        amode_nxt = amode_r;
        addr_nxt = addr_r;
        items_nxt = items_r;
        wide_nxt = wide_r;
        array_nxt = array_r;
        end_stop_nxt = end_stop_r;
        item_nxt = item_r;
        second_nxt = second_r;
        hi_nxt = hi_r;
        err_nxt = err_r;
        done_nxt = 1'b0;
        dv_nxt = 1'b0;
        data_nxt = data_r;
        idx_nxt = idx_r;
        dlast_nxt = dlast_r;
        if (st.cmd_valid) begin
            wait_nxt = 1'b1;
        end
        if (state_r == C_IDLE) begin
            if (i_go) begin
                op_nxt = i_op;
                ctrl_nxt = i_ctrl;
                amode_nxt = i_addr_mode;
                addr_nxt = i_addr;
                // an empty count still reads one value so the frame closes cleanly
                items_nxt = (count_in == 8'h00) ? 8'h01 : count_in;
                wide_nxt = i_item_wide;
                array_nxt = i_array_fill && (i_op == OP_ADDR_LIST || i_op == OP_LOW_BYTE);
                end_stop_nxt = i_end_stop;
                item_nxt = 8'h00;
                second_nxt = 1'b0;
                err_nxt = 1'b0;
                wait_nxt = 1'b0;
                // bare reads skip start and addressing; the host frames them
                state_nxt = (i_op == OP_LOW_BYTE) ? C_READ : C_START;
            end
        end else if (wait_r && st.done) begin
            wait_nxt = 1'b0;
            case (state_r)
                C_START: state_nxt = C_CTRL;
                C_CTRL: begin
                    if (st.slave_nack) begin
                        err_nxt = 1'b1;
                        state_nxt = C_STOP;
                    end else if (amode_r == ADDR_16) begin
                        state_nxt = C_ADDR_HI;
                    end else if (amode_r == ADDR_8) begin
                        state_nxt = C_ADDR_LO;
                    end else begin
                        state_nxt = C_READ;
                    end
                end
                C_ADDR_HI: begin
                    err_nxt = st.slave_nack;
                    state_nxt = st.slave_nack ? C_STOP : C_ADDR_LO;
                end
                C_ADDR_LO: begin
                    err_nxt = st.slave_nack;
                    state_nxt = st.slave_nack ? C_STOP : C_READ;
                end
                C_READ: begin
                    if (wide_cur && !second_r) begin
                        // high byte first, low byte completes the word
                        hi_nxt = st.rx_byte;
                        second_nxt = 1'b1;
                    end else begin
                        dv_nxt = 1'b1;
                        data_nxt = wide_cur ? {hi_r, st.rx_byte} : {8'h00, st.rx_byte};
                        idx_nxt = item_r;
                        dlast_nxt = last_byte;
                        second_nxt = 1'b0;
                        item_nxt = item_r + 8'h01;
                        if (last_byte) begin
                            if (op_r != OP_LOW_BYTE || end_stop_r) begin
                                state_nxt = C_STOP;
                            end else begin
                                state_nxt = C_IDLE;
                                done_nxt = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    state_nxt = C_IDLE;
                    done_nxt = 1'b1;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // sequencer registers
    // --------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= C_IDLE;
            wait_r <= 1'b0;
            op_r <= OP_ADDR_VALUE;
            ctrl_r <= 8'h00;
            amode_r <= ADDR_NONE;
            addr_r <= 16'h0000;
            items_r <= 8'h01;
            wide_r <= 16'h0000;
            array_r <= 1'b0;
            end_stop_r <= 1'b0;
            item_r <= 8'h00;
            second_r <= 1'b0;
            hi_r <= 8'h00;
            err_r <= 1'b0;
            done_r <= 1'b0;
            dv_r <= 1'b0;
            data_r <= 16'h0000;
            idx_r <= 8'h00;
            dlast_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            op_r <= op_nxt;
            ctrl_r <= ctrl_nxt;
            amode_r <= amode_nxt;
            addr_r <= addr_nxt;
            items_r <= items_nxt;
            wide_r <= wide_nxt;
            array_r <= array_nxt;
            end_stop_r <= end_stop_nxt;
            item_r <= item_nxt;
            second_r <= second_nxt;
            hi_r <= hi_nxt;
            err_r <= err_nxt;
            done_r <= done_nxt;
            dv_r <= dv_nxt;
            data_r <= data_nxt;
            idx_r <= idx_nxt;
            dlast_r <= dlast_nxt;
        end
    end

    assign o_busy = (state_r != C_IDLE);
    assign o_done = done_r;
    assign o_nack_err = err_r;
    assign o_data_valid = dv_r;
    assign o_data = data_r;
    assign o_data_index = idx_r;
    assign o_data_last = dlast_r;

endmodule : i2c_master_read_sequencer

// ===== dv/i2c_slave_model.sv
/* Behavioural I2C slave: acks its own read address, then sends bytes
   counting up from the last byte written. Assumes pull-ups in the bench. */
`timescale 1ns/100ps
module i2c_slave_model #(parameter logic [6:0] DEV = 7'h50) (
    // bus lines and address byte count
    input wire logic i_sda,
    input wire logic i_scl,
    input wire logic [1:0] i_addr_bytes,
    // pull data low
    output logic o_sda_low
);
    int bitc = 0;
    int nb = 0;
    logic act = 0;
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = 8'h00;
    initial o_sda_low = 1'b0;
    // start and stop: data edges while the clock is high
    always @(negedge i_sda) if (i_scl) begin
        act = 1'b1;
        bitc = -1;
        nb = 0;
    end
    always @(posedge i_sda) if (i_scl) begin
        act = 1'b0;
        o_sda_low = 1'b0;
    end
    // sample on the high clock; a master nack ends the read
    always @(posedge i_scl) if (act) begin
        if (bitc >= 0 && bitc < 8) sh = {sh[6:0], i_sda};
        if (bitc == 8 && nb > i_addr_bytes && i_sda) act = 1'b0;
    end
    // change data only while the clock is low
    always @(negedge i_scl) if (act) begin
        if (bitc == 8) begin
            bitc = 0;
            nb = nb + 1;
            tx = (nb == i_addr_bytes + 1) ? sh : tx + 8'h01;
            o_sda_low = (nb > i_addr_bytes) ? !tx[7] : 1'b0;
        end else if (bitc == 7) begin
            bitc = 8;
            if (nb > i_addr_bytes) o_sda_low = 1'b0;
            else if (nb == 0 && sh != {DEV, 1'b1}) begin
                act = 1'b0;
                o_sda_low = 1'b0;
            end else o_sda_low = 1'b1;
        end else begin
            bitc = bitc + 1;
            if (nb > i_addr_bytes && bitc > 0) o_sda_low = !tx[7 - bitc];
        end
    end
endmodule : i2c_slave_model

// ===== dv/seq_checker.sv
/* Port assertions for the read sequencer.
   Assumes the bind below reaches every sequencer instance. */
`timescale 1ns/100ps
module seq_checker (
    // watched ports
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_nack_err,
    input wire logic o_data_valid,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic o_scl_o,
    input wire logic o_scl_oe
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // ----------------------------------------------------------------
    // handshake and pins
    // ----------------------------------------------------------------
    go_taken_a: assert property (i_go && !o_busy |=> o_busy) else $error("go not taken");
    busy_cause_a: assert property ($rose(o_busy) |-> $past(i_go))
        else $error("busy uncaused");
    done_pulse_a: assert property (o_done |-> !o_busy ##1 !o_done)
        else $error("done form");
    pins_low_a: assert property (!o_sda_o && !o_scl_o) else $error("pin drives high");
    idle_free_a: assert property (!o_busy |-> !o_sda_oe) else $error("data held idle");
    valid_busy_a: assert property (o_data_valid |-> o_busy || o_done)
        else $error("value while idle");
    nack_quiet_a: assert property (o_nack_err |-> !o_data_valid)
        else $error("data after nack");
    // each clock edge is followed by eight stable cycles, so no glitch edges
    scl_hold_a: assert property ($changed(o_scl_oe) |=> $stable(o_scl_oe) [*8])
        else $error("clock phase short");
endmodule : seq_checker
bind i2c_master_read_sequencer seq_checker chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_go(i_go), .o_busy(o_busy), .o_done(o_done), .o_nack_err(o_nack_err),
    .o_data_valid(o_data_valid), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
    .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe));

// ===== dv/tb_top.sv
/* Self-checking bench: sequencer against a slave model and a queue model.
   Assumes pull-ups on both lines, modelled by the wire equations. */
`timescale 1ns/100ps
module tb_top;
    import i2c_rd_pkg::*;
    logic i_core_clk = 0, i_rst = 1, i_go = 0, f = 0, g = 0, s = 0, nack_x = 0, es = 1;
    rd_op_t p = OP_ADDR_VALUE;
    logic [1:0] m = 2'h0;
    logic [7:0] c = 8'h00, n = 8'h00, z = 8'h00, idx = 8'h00, last_idx = 8'h00;
    logic [15:0] a = 16'h0000, wd = 16'h0000, data;
    logic busy, done, nerr, dv, last, sda_o, sda_oe, scl_o, scl_oe, s_low;
    int bad_count = 0, checks_done = 0, seed = 32'h581daaa1, t;
    int exp_q[$];
    wire sda = !(sda_oe || s_low);
    wire scl = !scl_oe;
    i2c_master_read_sequencer uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_go(i_go),
        .i_op(p), .i_ctrl(c), .i_addr_mode(m), .i_addr(a), .i_item_count(n), .i_item_wide(wd),
        .i_array_fill(f), .i_len_given(g), .i_array_len(n), .i_array_size(z), .i_end_stop(es),
        .i_slow_bus(s), .o_busy(busy), .o_done(done), .o_nack_err(nerr), .o_data_valid(dv),
        .o_data(data), .o_data_index(idx), .o_data_last(last), .i_sda(sda), .o_sda_o(sda_o),
        .o_sda_oe(sda_oe), .i_scl(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe));
    i2c_slave_model slave (.i_sda(sda), .i_scl(scl), .i_addr_bytes(m), .o_sda_low(s_low));
    initial forever #25 i_core_clk = !i_core_clk;
    task chk(input string nm, input logic [15:0] e, input logic [15:0] v);
        checks_done++;
        if (e !== v) begin
            $display("mismatch %s expected %h seen %h", nm, e, v);
            bad_count++;
        end
    endtask : chk
    task test_done;
        if (bad_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    // ----------------------------------------------------------------
    // one request: build the expected values, start, wait for done
    // ----------------------------------------------------------------
    task run(input rd_op_t op, input logic [7:0] cc, input logic [1:0] mm, input logic [7:0] nn,
             input logic [7:0] zz, input logic [15:0] ww, input logic ff, input logic gg,
             input logic ss);
        int b, tot;
        @(negedge i_core_clk);
        p = op; c = cc; m = mm; n = nn; z = zz; wd = ww; f = ff; g = gg; s = ss;
        a = 16'($random(seed));
        b = (mm == ADDR_NONE) ? (cc | 8'h01) : a[7:0];
        nack_x = (op != OP_LOW_BYTE) && (cc[7:1] != 7'h50);
        tot = ff ? (gg ? nn : zz) : ((op == OP_ADDR_LIST) ? ((nn > 16) ? 16 : nn) : 1);
        if (tot == 0) tot = 1;
        // a released data line reads as all ones
        if (op == OP_LOW_BYTE) repeat (tot) exp_q.push_back(8'hFF);
        else if (!nack_x) for (int j = 0; j < tot; j++) begin
            if (!ff && op != OP_ADDR_BYTE && ww[(op == OP_ADDR_LIST) ? j : 0]) begin
                exp_q.push_back({b[7:0], 8'(b + 1)});
                b = b + 2;
            end else begin
                exp_q.push_back(b & 8'hFF);
                b = b + 1;
            end
        end
        last_idx = 8'h00;
        i_go = 1'b1;
        @(negedge i_core_clk);
        i_go = 1'b0;
        for (t = 0; t < 40000 && done !== 1'b1; t++) @(negedge i_core_clk);
        if (t == 40000) begin
            bad_count++;
            test_done();
        end
        // a stop-less read shows its last value with done; let it be compared first
        @(negedge i_core_clk);
        chk("values left", 16'h0, 16'(exp_q.size()));
        chk("nack flag", {15'h0, nack_x}, {15'h0, nerr});
        if (ss) chk("slow time", 16'h1, {15'h0, t > 10000});
    endtask : run
    // compare each value as it stands for its one cycle
    always @(negedge i_core_clk) if (dv === 1'b1) begin
        if (exp_q.size() == 0) chk("extra value", 16'h0, 16'h1);
        else begin
            chk("data", 16'(exp_q.pop_front()), data);
            chk("index", {8'h0, last_idx}, {8'h0, idx});
            chk("last", {15'h0, exp_q.size() == 0}, {15'h0, last});
            last_idx++;
        end
    end
    initial begin
        repeat (2) @(negedge i_core_clk);
        i_rst = 1'b0;
        run(OP_ADDR_VALUE, 8'hA0, ADDR_16, 8'h0, 8'h0, 16'h0001, 0, 0, 0);
        run(OP_ADDR_BYTE, 8'hA0, ADDR_8, 8'h0, 8'h0, 16'hFFFF, 0, 0, 1);
        run(OP_ADDR_LIST, 8'hA1, ADDR_NONE, 8'h2, 8'h0, 16'h0002, 0, 0, 0);
        run(OP_ADDR_LIST, 8'hA1, ADDR_8, 8'h3, 8'h5, 16'hFFFF, 1, 1, 0);
        run(OP_ADDR_LIST, 8'hA1, ADDR_8, 8'h9, 8'h2, 16'h0000, 1, 0, 0);
        run(OP_ADDR_VALUE, 8'hA5, ADDR_8, 8'h0, 8'h0, 16'h0000, 0, 0, 0);
        run(OP_LOW_BYTE, 8'h00, ADDR_NONE, 8'h0, 8'h0, 16'h0000, 0, 0, 0);
        es = 1'b0;
        run(OP_LOW_BYTE, 8'h00, ADDR_NONE, 8'h3, 8'h0, 16'h0000, 1, 1, 0);
        test_done();
    end
endmodule : tb_top
